// File: inc/vic_regs.vh
/*
 * register offsets, field positions, reset values and vector numbers
 * of the vectored interrupt controller.
 * assumes: included by the design file by its bare name.
 */
`ifndef VIC_REGS_VH
`define VIC_REGS_VH

// ----------------------------------------------------------------
// register offsets (apb byte address = 4 * index)
// ----------------------------------------------------------------
`define VIC_IDX_REQ_LOW     12'h0fc0
`define VIC_IDX_REQ_PIN     12'h0fc3
`define VIC_IDX_ENABLE      12'h0f00
`define VIC_IDX_PRIO_HI     12'h0f01
`define VIC_IDX_PRIO_LO     12'h0f02
`define VIC_IDX_EDGE_SEL    12'h0f03
`define VIC_IDX_CTRL        12'h0f04
`define VIC_IDX_VECTOR      12'h0f05
`define VIC_IDX_STATUS      12'h0f06
`define VIC_IDX_MASK        12'h0f07

// ----------------------------------------------------------------
// request low fields
// ----------------------------------------------------------------
`define VIC_RQL_TIMER_ONE   6
`define VIC_RQL_TIMER_ZERO  5
`define VIC_RQL_SER_RX      4
`define VIC_RQL_SER_TX      3
`define VIC_RQL_CONVERTER   0
`define VIC_RQL_USED_MASK   8'h79

// ----------------------------------------------------------------
// source numbering, highest fixed position first
// ----------------------------------------------------------------
`define VIC_NUM_SRC         20
`define VIC_NUM_PIN         12
`define VIC_NUM_SEL_EDGE    8
`define VIC_VEC_WATCHDOG    5'h14
`define VIC_VEC_NONE        5'h1f
`define VIC_RESET_BYTE      8'h00

// ----------------------------------------------------------------
// control and status bits
// ----------------------------------------------------------------
`define VIC_CTRL_GLOBAL_EN  0
`define VIC_CTRL_WDT_IRQ    1
`define VIC_ST_ACK          0
`define VIC_ST_WATCHDOG     1
`define VIC_ST_OSC_FAIL     2

`endif

// File: rtl/vic_controller.v
/*
 * vectored, prioritised interrupt controller with an apb register slave.
 * assumes: one clock sys_clk at 50 MHz, peripheral requests are
 * one-cycle pulses, pin inputs are synchronous to sys_clk, the core
 * fetches vector entries itself (upper byte even, lower byte odd).
 */
//
// Overview of operation
// [RQ1] arbitrate pending pin and peripheral requests, forward in priority order
// [RQ2] twenty distinct vectors, each selecting its own service routine
// [RQ3] twelve pin sources, eight peripheral sources, some slots shared
// [RQ4] eight pins selectable rising or falling edge, four trigger on both edges
// [RQ5] each source gets one of three priority levels honoured by arbitration
// [RQ6] watchdog time-out is a source when configured for interrupt
// [RQ7] vector entry: upper byte at even address, lower at next odd
// [RQ8] with polling, only record requests; never disturb the core
// [RQ9] watchdog and oscillator-fail traps bypass enable, priority, request
// [RQ10] a presented request sets its request bit until cleared
// [RQ11] globally enabled: latched pending request passed to the core
// [RQ12] globally disabled: software reads request register to find pending
// [RQ13] request bit 6 timer one, bit 5 timer zero
// [RQ14] request bit 4 serial receiver, bit 3 serial transmitter
// [RQ15] request bit 0 converter, absent when built without converter; code only drops the request, bit 0 stays software-settable
// [RQ16] some pin sources absent on small package builds
// [RQ17] equal priority: higher fixed vector position wins
// [RQ18] requests reset to zero; reserved bits 7, 2, 1 read zero
//
`timescale 1ns/1ns
`default_nettype none
`include "vic_regs.vh"

module vic_controller
#(
  parameter HAS_CONVERTER = 1,
  parameter [11:0] PIN_PRESENT = 12'hfff,
  parameter [15:0] VECTOR_BASE = 16'h0002
)
(
  // clock and reset
  input  wire        sys_clk,
  input  wire        arst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [15:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // sources
  input  wire        timer_one_request,
  input  wire        timer_zero_request,
  input  wire        serial_receive_request,
  input  wire        serial_transmit_request,
  input  wire        converter_request,
  input  wire [2:0]  periph_other_request,
  input  wire [11:0] pin_in,
  input  wire        watchdog_timeout,
  input  wire        osc_fail,
  // core side
  output wire        core_irq,
  output reg  [4:0]  core_vector,
  output reg  [15:0] core_vector_addr,
  input  wire        core_ack,
  output wire        irq
);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire [13:0] word = paddr[15:2];
  wire        wr   = psel && penable && pwrite;
  wire        rd_ok;
  // zero wait: every register answers in the access cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !rd_ok;
  wire hit_rql  = word == `VIC_IDX_REQ_LOW;
  wire hit_rqp  = word == `VIC_IDX_REQ_PIN;
  wire hit_en   = word == `VIC_IDX_ENABLE;
  wire hit_phi  = word == `VIC_IDX_PRIO_HI;
  wire hit_plo  = word == `VIC_IDX_PRIO_LO;
  wire hit_edg  = word == `VIC_IDX_EDGE_SEL;
  wire hit_ctl  = word == `VIC_IDX_CTRL;
  wire hit_vec  = word == `VIC_IDX_VECTOR;
  wire hit_st   = word == `VIC_IDX_STATUS;
  wire hit_msk  = word == `VIC_IDX_MASK;
  assign rd_ok = hit_rql | hit_rqp | hit_en | hit_phi | hit_plo | hit_edg
               | hit_ctl | hit_vec | hit_st | hit_msk;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg [19:0] enable;
  reg [19:0] prio_hi;
  reg [19:0] prio_lo;
  reg [7:0]  edge_sel;
  reg [1:0]  ctrl;
  reg [2:0]  status;
  reg [2:0]  mask;
  reg [19:0] pend;
  reg [11:0] pin_q;
  reg        wdt_pend;
  reg        osc_pend;

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      enable   <= 20'h0_0000;
      prio_hi  <= 20'h0_0000;
      prio_lo  <= 20'h0_0000;
      edge_sel <= `VIC_RESET_BYTE;
      ctrl     <= 2'h0;
      mask     <= 3'h0;
    end
    else if (wr)
    begin
      case (word)
        `VIC_IDX_ENABLE:
          enable   <= pwdata[19:0];
        `VIC_IDX_PRIO_HI:
          prio_hi  <= pwdata[19:0];
        `VIC_IDX_PRIO_LO:
          prio_lo  <= pwdata[19:0];
        `VIC_IDX_EDGE_SEL:
          edge_sel <= pwdata[7:0];
        `VIC_IDX_CTRL:
          ctrl     <= pwdata[1:0];
        `VIC_IDX_MASK:
          mask     <= pwdata[2:0];
        default:
          ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // source edge detection and request latching
  // ----------------------------------------------------------------
  // sources 19..0: [19] timer one .. order below is the fixed vector order
  wire [11:0] pin_rise = pin_in & ~pin_q;
  wire [11:0] pin_fall = ~pin_in & pin_q;
  wire [11:0] pin_evt;
  genvar g;
  generate
    for (g = 0; g < `VIC_NUM_PIN; g = g + 1)
    begin : g_pin
      if (g < `VIC_NUM_SEL_EDGE)
      begin : g_sel
        assign pin_evt[g] = PIN_PRESENT[g] &
          (edge_sel[g] ? pin_fall[g] : pin_rise[g]); // RQ4 RQ16
      end
      else
      begin : g_both
        assign pin_evt[g] = PIN_PRESENT[g] & (pin_rise[g] | pin_fall[g]); // RQ4
      end
    end
  endgenerate

  wire conv_evt = (HAS_CONVERTER != 0) & converter_request; // RQ15
  wire [19:0] src_evt = {timer_one_request, timer_zero_request,
                         serial_receive_request, serial_transmit_request,
                         periph_other_request, conv_evt, pin_evt}; // RQ3

  // fields of the low request register map onto the source vector
  wire [7:0] req_low = {1'b0, pend[19], pend[18], pend[17], pend[16],
                        2'b00, pend[12]}; // RQ13 RQ14 RQ15 RQ18

  // software clear (write zero) and set (write one) per source, except sources 15..13, which have no register bit, and pins absent from PIN_PRESENT
  reg [19:0] sw_wr_en;
  reg [19:0] sw_wr_val;
  always @*
  begin
    sw_wr_en  = 20'h0_0000;
    sw_wr_val = 20'h0_0000;
    if (wr && hit_rql)
    begin
      sw_wr_en[19:16] = 4'hf;
      sw_wr_en[12]    = 1'b1;
      sw_wr_val[19]   = pwdata[`VIC_RQL_TIMER_ONE];
      sw_wr_val[18]   = pwdata[`VIC_RQL_TIMER_ZERO];
      sw_wr_val[17]   = pwdata[`VIC_RQL_SER_RX];
      sw_wr_val[16]   = pwdata[`VIC_RQL_SER_TX];
      sw_wr_val[12]   = pwdata[`VIC_RQL_CONVERTER];
    end
    else if (wr && hit_rqp)
    begin
      sw_wr_en[11:0]  = PIN_PRESENT;
      sw_wr_val[11:0] = pwdata[11:0];
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  wire [19:0] active = pend & enable;
  wire [19:0] lvl3;
  wire [19:0] lvl2;
  wire [19:0] lvl1;
  generate
    for (g = 0; g < `VIC_NUM_SRC; g = g + 1)
    begin : g_lvl
      // hi and lo set: level 3, hi only: level 2, else level 1
      assign lvl3[g] = active[g] & prio_hi[g] & prio_lo[g];
      assign lvl2[g] = active[g] & prio_hi[g] & ~prio_lo[g];
      assign lvl1[g] = active[g] & ~prio_hi[g];
    end
  endgenerate
  // fixed order: a source kept busy at a high level starves lower ones
  wire [19:0] chosen_set = (|lvl3) ? lvl3 : (|lvl2) ? lvl2 : lvl1; // RQ5

  reg [4:0] win;
  integer i;
  always @*
  begin
    win = `VIC_VEC_NONE;
    for (i = 0; i < `VIC_NUM_SRC; i = i + 1)
      if (chosen_set[i])
        win = i[4:0]; // RQ17 RQ1
  end

  wire global_en = ctrl[`VIC_CTRL_GLOBAL_EN];
  wire wdt_live  = wdt_pend | osc_pend;
  reg  busy;
  // with global enable off no request reaches the core
  wire offer = global_en && !busy && (wdt_live || (|active)); // RQ8 RQ11
  wire [4:0] next_vec = wdt_live ? `VIC_VEC_WATCHDOG : win; // RQ9 RQ2
  wire ack_evt     = busy && core_ack;
  wire wdt_irq_evt = watchdog_timeout && ctrl[`VIC_CTRL_WDT_IRQ]; // RQ6
  wire trap_done   = ack_evt && (core_vector == `VIC_VEC_WATCHDOG);

  // ----------------------------------------------------------------
  // request latches, one per source
  // ----------------------------------------------------------------
  // a source firing in the cycle of a clear or an ack keeps its bit
  generate
    for (g = 0; g < `VIC_NUM_SRC; g = g + 1)
    begin : g_req
      localparam [4:0] SRC_IDX = g;
      wire served = ack_evt && (core_vector == SRC_IDX);
      always @(posedge sys_clk or negedge arst_n)
      begin
        if (!arst_n)
          pend[g] <= 1'b0; // RQ18
        else if (src_evt[g])
          pend[g] <= 1'b1; // RQ10
        else if (sw_wr_en[g])
          pend[g] <= sw_wr_val[g];
        else if (served)
          pend[g] <= 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // traps
  // ----------------------------------------------------------------
  // traps bypass enable, priority and request registers
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wdt_pend <= 1'b0;
      osc_pend <= 1'b0;
    end
    else
    begin
      if (wdt_irq_evt)
        wdt_pend <= 1'b1; // RQ6 RQ9
      else if (trap_done)
        wdt_pend <= 1'b0;
      if (osc_fail)
        osc_pend <= 1'b1; // RQ9
      else if (trap_done)
        osc_pend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // core offer
  // ----------------------------------------------------------------
  // one offer at a time; a newer request waits for the ack
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy             <= 1'b0;
      core_vector      <= `VIC_VEC_NONE;
      core_vector_addr <= 16'h0000;
    end
    else if (offer)
    begin
      busy             <= 1'b1;
      core_vector      <= next_vec;
      core_vector_addr <= VECTOR_BASE + {10'h000, next_vec, 1'b0}; // RQ7
    end
    else if (ack_evt)
      busy <= 1'b0;
  end

  assign core_irq = busy; // RQ11

  // pin_q resets low: a pin high at release shows one rising edge
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      pin_q <= 12'h000;
    else
      pin_q <= pin_in;
  end

  // ----------------------------------------------------------------
  // status and interrupt output
  // ----------------------------------------------------------------
  wire [2:0] st_evt;
  wire [2:0] st_clr = (wr && hit_st) ? pwdata[2:0] : 3'h0;
  assign st_evt[`VIC_ST_ACK]      = ack_evt;
  assign st_evt[`VIC_ST_WATCHDOG] = wdt_irq_evt;
  assign st_evt[`VIC_ST_OSC_FAIL] = osc_fail;

  // an event in the cycle of a one-write still sets its bit
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      status <= 3'h0;
    else
      status <= (status & ~st_clr) | st_evt;
  end

  // level output, stays high until software clears or masks
  assign irq = |(status & mask);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // unmapped words read zero; pslverr flags them
  always @*
  begin
    prdata = 32'h0000_0000;
    case (word)
      `VIC_IDX_REQ_LOW:
        prdata = {24'h00_0000, req_low}; // RQ12 RQ18
      `VIC_IDX_REQ_PIN:
        prdata = {20'h0_0000, pend[11:0]};
      `VIC_IDX_ENABLE:
        prdata = {12'h000, enable};
      `VIC_IDX_PRIO_HI:
        prdata = {12'h000, prio_hi};
      `VIC_IDX_PRIO_LO:
        prdata = {12'h000, prio_lo};
      `VIC_IDX_EDGE_SEL:
        prdata = {24'h00_0000, edge_sel};
      `VIC_IDX_CTRL:
        prdata = {30'h0000_0000, ctrl};
      // vector overlays the low address bits; software masks what it needs
      `VIC_IDX_VECTOR:
        prdata = {15'h0000, busy, core_vector_addr} | {27'h000_0000, core_vector};
      `VIC_IDX_STATUS:
        prdata = {29'h0000_0000, status};
      `VIC_IDX_MASK:
        prdata = {29'h0000_0000, mask};
      default:
        prdata = 32'h0000_0000;
    endcase
  end

endmodule // vic_controller

`default_nettype wire

// File: testbench/vic_monitor.sv
/* assertions on the controller ports.
   assumes: bound to vic_controller, single clock sys_clk. */
`timescale 1ns/1ns
`default_nettype none
`include "vic_regs.vh"
module vic_monitor
#(parameter logic [15:0] VECTOR_BASE = 16'h0002)
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        arst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  // sources and core
  input wire logic        timer_one_request,
  input wire logic        watchdog_timeout,
  input wire logic        core_irq,
  input wire logic [4:0]  core_vector,
  input wire logic [15:0] core_vector_addr,
  input wire logic        core_ack
);
  logic      glb;
  logic      wen;
  logic      t1_seen;
  wire logic rq = psel & penable & !pwrite & (paddr == {`VIC_IDX_REQ_LOW, 2'b00});
  // ----
  // ctrl shadow, updated on the edge the write lands
  // ----
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      glb <= 1'b0;
      wen <= 1'b0;
    end
    else if (psel && penable && pwrite && pready && paddr == {`VIC_IDX_CTRL, 2'b00})
    begin
      glb <= pwdata[0];
      wen <= pwdata[1];
    end
  end
  // timer one seen since the last software write or ack of its bit
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      t1_seen <= 1'b0;
    else if (timer_one_request)
      t1_seen <= 1'b1;
    else if ((psel && penable && pwrite && pready && paddr == {`VIC_IDX_REQ_LOW, 2'b00})
             || (core_ack && core_vector == 5'd19))
      t1_seen <= 1'b0;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  rst_state_a: assert property ($rose(arst_n) |-> !core_irq && core_vector == 5'h1f)
    else $error("offer state wrong after reset");
  vec_range_a: assert property (core_irq |-> core_vector <= 5'd20)
    else $error("vector out of range");
  vec_addr_a: assert property (core_irq |-> core_vector_addr == VECTOR_BASE + {core_vector, 1'b0})
    else $error("vector address wrong");
  offer_hold_a: assert property (core_irq && !core_ack |=> core_irq && $stable(core_vector))
    else $error("offer changed before ack");
  ack_end_a: assert property (core_ack |=> !core_irq)
    else $error("offer kept after ack");
  poll_quiet_a: assert property (!glb && !core_irq |=> !core_irq)
    else $error("offer while globally disabled");
  req_set_a: assert property (rq && t1_seen |-> prdata[6])
    else $error("request bit not set");
  rsvd_zero_a: assert property (rq |-> prdata[31:7] == 25'h0 && prdata[2:1] == 2'b00)
    else $error("reserved bits not zero");
  wdt_offer_a: assert property (watchdog_timeout && glb && wen && !core_irq ##1 glb && !core_irq
    |=> core_irq && core_vector == `VIC_VEC_WATCHDOG)
    else $error("watchdog not offered");
  cover property (core_ack);
  cover property (core_irq && core_vector == `VIC_VEC_WATCHDOG);
  cover property (rq && prdata[6]);
endmodule // vic_monitor
bind vic_controller vic_monitor #(.VECTOR_BASE(VECTOR_BASE)) u_vic_monitor (.*);
`default_nettype wire

// File: testbench/vic_core_model.sv
/* core model: takes each offered vector and acknowledges it.
   assumes: lag is held steady while an offer stands. */
`timescale 1ns/1ns
`default_nettype none
module vic_core_model
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       arst_n,
  // offer side
  input wire logic       core_irq,
  input wire logic [3:0] lag,
  output logic           core_ack
);
  logic [3:0] cnt;
  // one ack pulse per offer; lag models a slow service entry
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt      <= 4'h0;
      core_ack <= 1'b0;
    end
    else if (core_ack)
    begin
      cnt      <= 4'h0;
      core_ack <= 1'b0;
    end
    else if (core_irq)
    begin
      cnt      <= cnt + 4'h1;
      core_ack <= (cnt == lag);
    end
  end
endmodule // vic_core_model
`default_nettype wire

// File: testbench/vectored_interrupt_controller_bench.sv
/* self-checking bench: apb master, sources, core model.
   assumes: vic_monitor bound, sys_clk 50 MHz. */
`timescale 1ns/1ns
`default_nettype none
`include "vic_regs.vh"
module vectored_interrupt_controller_bench;
  localparam logic [15:0] VB  = 16'h0100;
  localparam logic [15:0] RQL = {`VIC_IDX_REQ_LOW, 2'b00};
  localparam logic [15:0] PIN = {`VIC_IDX_REQ_PIN, 2'b00};
  localparam logic [15:0] CT  = {`VIC_IDX_CTRL, 2'b00};
  localparam logic [15:0] MK  = {`VIC_IDX_MASK, 2'b00};
  localparam logic [15:0] ST  = {`VIC_IDX_STATUS, 2'b00};
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wdt = 1'b0, osc = 1'b0, err;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, q, q2;
  wire logic [31:0] prdata_nc;
  logic [4:0]  pk = 5'h00;
  logic [11:0] pin_in = 12'h000;
  logic [3:0]  lag = 4'h0;
  wire logic        pready, pslverr, core_irq, core_ack, irq;
  wire logic [31:0] prdata;
  wire logic [4:0]  core_vector;
  wire logic [15:0] core_vector_addr;
  int n_errors = 0, tests_run = 0;
  vic_controller #(.VECTOR_BASE(VB)) u_vic_controller (.sys_clk(sys_clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .timer_one_request(pk[4]),
    .timer_zero_request(pk[3]), .serial_receive_request(pk[2]),
    .serial_transmit_request(pk[1]), .converter_request(pk[0]),
    .periph_other_request(3'b000), .pin_in(pin_in), .watchdog_timeout(wdt),
    .osc_fail(osc), .core_irq(core_irq), .core_vector(core_vector),
    .core_vector_addr(core_vector_addr), .core_ack(core_ack), .irq(irq));
  // small build: no converter, pin 0 absent; shares the bus, read via q2
  vic_controller #(.HAS_CONVERTER(0), .PIN_PRESENT(12'hffe)) u_vic_controller_small (
    .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(prdata_nc), .pslverr(),
    .timer_one_request(pk[4]), .timer_zero_request(pk[3]), .serial_receive_request(pk[2]),
    .serial_transmit_request(pk[1]), .converter_request(pk[0]),
    .periph_other_request(3'b000), .pin_in(pin_in), .watchdog_timeout(1'b0),
    .osc_fail(1'b0), .core_irq(), .core_vector(), .core_vector_addr(), .core_ack(1'b0),
    .irq());
  vic_core_model u_vic_core_model (.sys_clk(sys_clk), .arst_n(arst_n),
    .core_irq(core_irq), .lag(lag), .core_ack(core_ack));
  always #10 sys_clk = ~sys_clk;
  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
    tests_run++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    q = prdata;
    q2 = prdata_nc;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [15:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e, n);
  endtask
  task automatic wi(input logic [15:0] a, input logic [31:0] d, input logic e);
    bus(1'b1, a, d);
    @(negedge sys_clk);
    chk(irq, e, "irq");
  endtask
  task automatic offer(input logic [4:0] v);
    for (int i = 0; i < 100 && core_irq !== 1'b1; i++)
      @(posedge sys_clk);
    chk(core_vector, v, "vector");
    chk(core_vector_addr, VB + {v, 1'b0}, "vec_addr");
    for (int i = 0; i < 100 && core_irq !== 1'b0; i++)
      @(posedge sys_clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #(20 * 5000);
    n_errors++;
    report_and_stop;
  end
  initial
  begin
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    rc(RQL, 32'h0000_0000, "rql_reset");
    rc(16'h3ffc, 32'h0000_0000, "unmapped");
    chk(err, 1'b1, "slverr");
    bus(1'b1, {`VIC_IDX_ENABLE, 2'b00}, 32'h000f_ffff);
    // pin 1 on falling edge only
    bus(1'b1, {`VIC_IDX_EDGE_SEL, 2'b00}, 32'h0000_0002);
    @(posedge sys_clk);
    pk <= 5'h1f;
    @(posedge sys_clk);
    pk <= 5'h00;
    pin_in <= 12'h103;
    rc(RQL, 32'h0000_0079, "rql_poll");
    chk(q2, 32'h0000_0078, "rql_noconv");
    chk(core_irq, 1'b0, "poll_quiet");
    rc(PIN, 32'h0000_0101, "pin_rise");
    chk(q2, 32'h0000_0100, "pin_absent");
    pin_in <= 12'h000;
    rc(PIN, 32'h0000_0103, "pin_fall");
    bus(1'b1, RQL, 32'h0000_00ff);
    rc(RQL, 32'h0000_0079, "rql_rsvd");
    bus(1'b1, RQL, 32'h0000_0000);
    bus(1'b1, PIN, 32'h0000_0000);
    rc(RQL, 32'h0000_0000, "rql_clear");
    // timer zero level 3, serial tx level 2, the rest level 1
    bus(1'b1, {`VIC_IDX_PRIO_HI, 2'b00}, 32'h0005_0000);
    bus(1'b1, {`VIC_IDX_PRIO_LO, 2'b00}, 32'h0004_0000);
    @(posedge sys_clk);
    pk <= 5'h1e;
    lag <= 4'h3;
    @(posedge sys_clk);
    pk <= 5'h00;
    bus(1'b1, CT, 32'h0000_0001);
    offer(5'd18);
    offer(5'd16);
    offer(5'd19);
    offer(5'd17);
    rc(RQL, 32'h0000_0000, "rql_served");
    wi(MK, 32'h0000_0001, 1'b1);
    wi(MK, 32'h0000_0000, 1'b0);
    wi(MK, 32'h0000_0001, 1'b1);
    wi(ST, 32'h0000_0001, 1'b0);
    rc(ST, 32'h0000_0000, "status");
    bus(1'b1, {`VIC_IDX_ENABLE, 2'b00}, 32'h0000_0000);
    bus(1'b1, CT, 32'h0000_0003);
    @(posedge sys_clk);
    wdt <= 1'b1;
    lag <= 4'h0;
    @(posedge sys_clk);
    wdt <= 1'b0;
    offer(`VIC_VEC_WATCHDOG);
    rc(ST, 32'h0000_0003, "st_wdt");
    @(posedge sys_clk);
    osc <= 1'b1;
    @(posedge sys_clk);
    osc <= 1'b0;
    offer(`VIC_VEC_WATCHDOG);
    rc(ST, 32'h0000_0007, "st_trap");
    report_and_stop;
  end
endmodule // vectored_interrupt_controller_bench
`default_nettype wire
